//--- src/flash_host_pkg.sv
// package of constants and carriers for the nand flash host controller
`default_nettype none
package flash_host_pkg;
  localparam int BUS_W = 8;
  localparam int BLOCKS = 1024;
  localparam int PAGES_PER_BLOCK = 64;
  localparam int MAIN_BYTES = 2048;
  localparam int SPARE_BYTES = 64;
  localparam int PAGE_BYTES = MAIN_BYTES + SPARE_BYTES;
  localparam int ADDR_CYCLES = 4;
  localparam int COL_BITS = 12;
  localparam int ROW_BITS = 16;
  localparam logic [3:0] COL_HI_MASK = 4'hf;
  // strobe timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RD_CYCLE_NS = 25;
  localparam int RD_CYCLE_CLKS_RAW = (RD_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PHASE_CLKS = (RD_CYCLE_CLKS_RAW + 1) / 2;
  localparam int PHASE_W = 4;
  localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(PHASE_CLKS - 1);
  localparam logic [PHASE_W-1:0] PHASE_ZERO = 4'h0;
  localparam int ECC_SPAN_BYTES = 528;
  localparam logic [1:0] KIND_CMD = 2'h0;
  localparam logic [1:0] KIND_ADDR = 2'h1;
  localparam logic [1:0] KIND_WDATA = 2'h2;
  localparam logic [1:0] KIND_RDATA = 2'h3;

  typedef struct packed {
    logic [1:0] kind;
    logic [BUS_W-1:0] data;
  } xfer_req_s;

  typedef struct packed {
    logic chip_sel_n;
    logic cmd_latch;
    logic addr_latch;
    logic write_strobe_n;
    logic read_strobe_n;
    logic write_prot_n;
  } flash_ctl_s;
endpackage : flash_host_pkg
`default_nettype wire

//--- src/strobe_timer.sv
// phase counter that paces each strobe half cycle
`default_nettype none
module strobe_timer
  import flash_host_pkg::*;
#(
  parameter logic [PHASE_W-1:0] LAST = PHASE_LAST
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic start,
  output logic done
);
  logic [PHASE_W-1:0] count_reg;
  logic run_reg;

  // counts LAST+1 cycles after start, done is a one-cycle pulse
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= PHASE_ZERO;
      run_reg <= 1'b0;
    end else if (clk_en) begin
      if (start) begin
        count_reg <= PHASE_ZERO;
        run_reg <= 1'b1;
      end else if (run_reg && count_reg == LAST) begin
        run_reg <= 1'b0;
      end else if (run_reg) begin
        count_reg <= count_reg + 1'b1;
      end
    end
  end

  // done ignores start, so the sequencer's restart path stays free of a combinational loop
  assign done = run_reg && (count_reg == LAST);
endmodule : strobe_timer
`default_nettype wire

//--- src/flash_host.sv
// host-side pin sequencer for an 8-bit multiplexed nand flash
`default_nettype none
module flash_host
  import flash_host_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire xfer_req_s req,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic write_prot_req_n,
  input wire logic hold_select,
  output logic [BUS_W-1:0] rd_data,
  output logic rd_valid,
  output logic dev_ready,
  output flash_ctl_s ctl,
  input wire logic [BUS_W-1:0] io_in,
  output logic [BUS_W-1:0] io_out,
  output logic io_oe,
  input wire logic ready_busy_n,
  output logic ready_busy_oe
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_STROBE = 2'b11,
    ST_HOLD = 2'b10
  } seq_e;

  seq_e state_reg;
  xfer_req_s cur_reg;
  logic timer_start;
  logic timer_done;
  logic take;
  logic rb_q_reg;
  logic sel_n_reg;

  // host never pulls ready/busy; pull-up lives on the board
  assign ready_busy_oe = 1'b0;

  strobe_timer #(.LAST(PHASE_LAST)) u_timer (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .start(timer_start),
    .done(timer_done)
  );

  // requests taken only from idle so strobes never overlap
  assign req_ready = (state_reg == ST_IDLE);
  assign take = req_ready && req_valid;
  assign timer_start = take || (timer_done && state_reg != ST_HOLD);

  // sequencer: select, strobe low phase, strobe high hold phase
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
    end else if (clk_en) begin
      unique case (state_reg)
        ST_IDLE: begin
          if (take) begin
            state_reg <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (timer_done) begin
            state_reg <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          if (timer_done) begin
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (timer_done) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // captured request stays stable through the whole strobe
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cur_reg <= '0;
    end else if (clk_en && take) begin
      cur_reg <= req;
    end
  end

  // chip select falls on take, before any strobe edge
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sel_n_reg <= 1'b1;
    end else if (clk_en) begin
      if (take) begin
        sel_n_reg <= 1'b0;
      end else if (state_reg == ST_IDLE && !hold_select) begin
        sel_n_reg <= 1'b1;
      end
    end
  end

  // pin drive: only one latch enable ever, host bus released on reads
  always_comb begin
    ctl.chip_sel_n = sel_n_reg;
    ctl.cmd_latch = (state_reg != ST_IDLE) && (cur_reg.kind == KIND_CMD);
    ctl.addr_latch = (state_reg != ST_IDLE) && (cur_reg.kind == KIND_ADDR);
    ctl.write_strobe_n = !((state_reg == ST_STROBE) && (cur_reg.kind != KIND_RDATA));
    ctl.read_strobe_n = !((state_reg == ST_STROBE) && (cur_reg.kind == KIND_RDATA));
    ctl.write_prot_n = write_prot_req_n;
  end

  // bus driven for writes only, so the device may drive during reads
  assign io_oe = (state_reg != ST_IDLE) && (cur_reg.kind != KIND_RDATA);
  assign io_out = cur_reg.data;

  // read byte sampled just before read strobe rises
  // bytes pass uncorrected: user logic must correct one bit per ECC_SPAN_BYTES span
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= '0;
      rd_valid <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= 1'b0;
      if (state_reg == ST_STROBE && timer_done && cur_reg.kind == KIND_RDATA) begin
        rd_data <= io_in;
        rd_valid <= 1'b1;
      end
    end
  end

  // busy level registered; pin assumed synchronous
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rb_q_reg <= 1'b0;
    end else if (clk_en) begin
      rb_q_reg <= ready_busy_n;
    end
  end
  assign dev_ready = rb_q_reg;

  // select and latch qualifiers around every strobe
  // pins are only seen at clock edges, so sub-cycle setup is not checked here
  one_latch_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !(ctl.cmd_latch && ctl.addr_latch))
    else $error("both latch enables high");
  sel_before_we_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $fell(ctl.write_strobe_n) |-> !ctl.chip_sel_n && !$past(ctl.chip_sel_n))
    else $error("write strobe without prior select");
  strobe_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!ctl.write_strobe_n || !ctl.read_strobe_n) |-> !ctl.chip_sel_n)
    else $error("strobe low while deselected");
  latch_stable_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && $rose(ctl.write_strobe_n)) |->
    $stable(ctl.cmd_latch) && $stable(ctl.addr_latch))
    else $error("latch enable moved at strobe rise");
  addr_latch_we_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !ctl.write_strobe_n && cur_reg.kind == KIND_ADDR |-> ctl.addr_latch && !ctl.cmd_latch)
    else $error("address strobe without latch");

  // write side: bus driven by the host and held across the strobe
  data_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && $rose(ctl.write_strobe_n)) |-> io_oe && $stable(io_out))
    else $error("bus changed at write strobe rise");
  write_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !ctl.write_strobe_n |-> io_oe)
    else $error("write strobe with bus released");
  write_low_len_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && $fell(ctl.write_strobe_n)) |-> !ctl.write_strobe_n [*2])
    else $error("write strobe low too short");
  one_strobe_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !(!ctl.write_strobe_n && !ctl.read_strobe_n))
    else $error("both strobes low");

  // read side: bus released, strobe width, capture pulse
  no_drive_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !ctl.read_strobe_n |-> !io_oe)
    else $error("host drives bus during read");
  read_low_len_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && $fell(ctl.read_strobe_n)) |-> !ctl.read_strobe_n [*2])
    else $error("read strobe low too short");
  read_capture_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && $rose(ctl.read_strobe_n)) |-> rd_valid)
    else $error("read byte not captured");
  read_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && rd_valid) |=> !rd_valid)
    else $error("read valid longer than one cycle");

  // handshake and device status
  take_ready_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && req_valid && req_ready) |=> !req_ready)
    else $error("second request taken during transfer");
  ready_copy_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en |=> dev_ready == $past(ready_busy_n))
    else $error("ready flag does not follow pin");
  rb_float_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !ready_busy_oe)
    else $error("host drove ready busy");
endmodule : flash_host
`default_nettype wire

//--- bench/flash_dev_model.sv
// behavioural nand flash device on the far side of the pins
`default_nettype none
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter int RD_BUSY = 20,
  parameter int PG_BUSY = 40,
  parameter int ER_BUSY = 60
) (
  input wire logic clk_sys,
  input wire flash_ctl_s ctl,
  input wire logic [BUS_W-1:0] io_out,
  input wire logic io_oe,
  input wire logic host_rb_oe,
  output logic [BUS_W-1:0] io_in,
  output logic ready_busy_n,
  output logic [7:0] last_cmd,
  output logic [11:0] col,
  output logic [15:0] row,
  output int programs
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] acnt = 2'h0;
  logic we_q = 1'b1;
  logic re_q = 1'b1;
  logic [7:0] last_bus = 8'h00;
  int busy = 0;
  wire logic sel = !ctl.chip_sel_n;
  wire logic drv = sel && !ctl.read_strobe_n;
  // floating bus shows the inverse of its last level, never a lucky match
  assign io_in = io_oe ? io_out : drv ? col[7:0] + 8'h5a : ~last_bus;
  // open drain wire-and with pull-up
  assign ready_busy_n = (busy > 0 || host_rb_oe) ? 1'b0 : 1'b1;
  // strobe edges seen by sampling, pins only
  always @(posedge clk_sys) begin
    we_q <= ctl.write_strobe_n;
    re_q <= ctl.read_strobe_n;
    last_bus <= io_in;
    if (busy > 0) busy <= busy - 1;
    if (sel && ctl.write_strobe_n && !we_q) begin
      if (ctl.cmd_latch) begin
        last_cmd <= io_in;
        if (io_in == 8'h30) busy <= RD_BUSY;
        if (io_in == 8'h10 && ctl.write_prot_n) begin
          busy <= PG_BUSY;
          programs <= programs + 1;
        end
        if (io_in == 8'hd0 && ctl.write_prot_n) busy <= ER_BUSY;
      end else if (ctl.addr_latch) begin
        case (acnt)
          2'h0: col[7:0] <= io_in;
          2'h1: col[11:8] <= io_in[3:0];
          2'h2: row[7:0] <= io_in;
          default: row[15:8] <= io_in;
        endcase
        acnt <= acnt + 2'h1;
      end
    end
    if (sel && ctl.read_strobe_n && !re_q) col <= (col == PAGE_BYTES - 1) ? 12'h0 : col + 12'h1;
  end
endmodule : flash_dev_model
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench for the nand flash host controller
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_host_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  xfer_req_s req = '0;
  logic req_valid = 1'b0;
  logic write_prot_req_n = 1'b1;
  logic hold_select = 1'b0;
  logic req_ready, rd_valid, dev_ready, io_oe, ready_busy_n, ready_busy_oe;
  logic [7:0] rd_data, io_out, io_in, last_cmd;
  logic [11:0] col;
  logic [15:0] row;
  flash_ctl_s ctl;
  int programs;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  flash_host flash_host_i (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .write_prot_req_n(write_prot_req_n),
    .hold_select(hold_select), .rd_data(rd_data), .rd_valid(rd_valid), .dev_ready(dev_ready),
    .ctl(ctl), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .ready_busy_n(ready_busy_n),
    .ready_busy_oe(ready_busy_oe));
  flash_dev_model flash_dev_model_i (.clk_sys(clk_sys), .ctl(ctl), .io_out(io_out),
    .io_oe(io_oe), .host_rb_oe(ready_busy_oe), .io_in(io_in), .ready_busy_n(ready_busy_n),
    .last_cmd(last_cmd), .col(col), .row(row), .programs(programs));
  always #2.5 clk_sys = ~clk_sys;
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  // offer one request and hold it until the controller takes it
  task automatic send(input logic [1:0] k, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    req <= '{kind: k, data: d};
    req_valid <= 1'b1;
    @(negedge clk_sys);
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 50) n_errors++;
    @(posedge clk_sys);
    req_valid <= 1'b0;
  endtask : send
  task automatic read_byte(input logic [7:0] exp);
    int n;
    send(KIND_RDATA, 8'h00);
    for (n = 0; n < 20 && rd_valid !== 1'b1; n++) @(negedge clk_sys);
    check(rd_valid, 1'b1, "read answered");
    check(rd_data, exp, "read byte");
  endtask : read_byte
  task automatic test_address;
    send(KIND_CMD, 8'h00);
    send(KIND_ADDR, 8'h10);
    send(KIND_ADDR, 8'h01);
    send(KIND_ADDR, 8'h45);
    send(KIND_ADDR, 8'h03);
    repeat (12) @(posedge clk_sys);
    check(last_cmd, 8'h00, "command");
    check(col, 12'h110, "column");
    check(row, 16'h0345, "row");
    $display("address test done");
  endtask : test_address
  task automatic test_read;
    int n;
    send(KIND_CMD, 8'h30);
    repeat (12) @(negedge clk_sys);
    check(dev_ready, 1'b0, "busy");
    for (n = 0; n < 100 && dev_ready !== 1'b1; n++) @(negedge clk_sys);
    check(dev_ready, 1'b1, "ready");
    read_byte(8'h6a);
    read_byte(8'h6b);
    read_byte(8'h6c);
    $display("read test done");
  endtask : test_read
  task automatic test_protect;
    int n;
    @(posedge clk_sys);
    write_prot_req_n <= 1'b0;
    send(KIND_CMD, 8'h10);
    repeat (12) @(negedge clk_sys);
    check(ctl.write_prot_n, 1'b0, "protect pin");
    check(programs[15:0], 16'h0, "blocked program");
    @(posedge clk_sys);
    write_prot_req_n <= 1'b1;
    send(KIND_CMD, 8'h10);
    repeat (12) @(negedge clk_sys);
    check(programs[15:0], 16'h1, "program");
    for (n = 0; n < 100 && dev_ready !== 1'b1; n++) @(negedge clk_sys);
    check(dev_ready, 1'b1, "program done");
    send(KIND_CMD, 8'hd0);
    repeat (12) @(negedge clk_sys);
    check(dev_ready, 1'b0, "erase busy");
    $display("protect test done");
  endtask : test_protect
  task automatic test_select;
    @(posedge clk_sys);
    hold_select <= 1'b1;
    send(KIND_WDATA, 8'h5c);
    repeat (14) @(negedge clk_sys);
    check(ctl.chip_sel_n, 1'b0, "held select");
    @(posedge clk_sys);
    hold_select <= 1'b0;
    repeat (4) @(negedge clk_sys);
    check(ctl.chip_sel_n, 1'b1, "released select");
    $display("select test done");
  endtask : test_select
  // clock enable low mid-transfer must freeze the sequence
  task automatic test_freeze;
    send(KIND_WDATA, 8'ha5);
    clk_en <= 1'b0;
    repeat (10) @(negedge clk_sys);
    check(req_ready, 1'b0, "frozen busy");
    check(ctl.write_strobe_n, 1'b1, "frozen strobe");
    @(posedge clk_sys);
    clk_en <= 1'b1;
    repeat (12) @(negedge clk_sys);
    check(req_ready, 1'b1, "resumed idle");
    $display("freeze test done");
  endtask : test_freeze
  // second reset in mid-run, then a read right after release
  task automatic test_reset;
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(negedge clk_sys);
    check({ctl.chip_sel_n, io_oe, rd_valid, req_ready}, 4'h9, "reset idle");
    check({ctl.write_strobe_n, ctl.read_strobe_n}, 2'h3, "reset strobes");
    @(posedge clk_sys);
    rst_b <= 1'b1;
    read_byte(8'h6d);
    $display("reset test done");
  endtask : test_reset
  initial begin
    repeat (12) @(posedge clk_sys);
    check(ctl.chip_sel_n, 1'b1, "reset select");
    check({ctl.write_strobe_n, ctl.read_strobe_n, io_oe}, 3'h6, "reset strobes");
    rst_b <= 1'b1;
    $display("reset test done");
    test_address();
    test_read();
    test_protect();
    test_select();
    test_freeze();
    test_reset();
    finish_test();
  end
endmodule : testbench
`default_nettype wire
